// *** cml_line_maint.sv ***
// cml_line_maint.sv: cache line prefetch, write-back and invalidate
//
// Operation
// [R1] every operation acts on one whole 32-byte line, data or instruction
// [R2] prefetch fills the line only on a miss with page_cacheable_bit set
// [R3] prefetch does nothing on a hit or while a fill is in progress
// [R4] write-back of a dirty hit writes the line out, then marks it clean
// [R5] write-back of a clean or absent line does nothing
// [R6] write-back-invalidate writes a dirty line out, then invalidates it
// [R7] write-back-invalidate on a miss does nothing
// [R8] instruction invalidate clears validity and never writes anything back
// [R9] no exceptions; a protection violation makes the operation a no-op
// [R10] post-increment form adds 32 bytes to the pointer
// [R11] the core issues each operation alone, never in parallel
// [R12] a store under write-back policy marks the hit line dirty
// [R13] the low five address bits are ignored when selecting a line
`timescale 1ns/10ps
`default_nettype none
module cml_line_maint (
   input  wire logic                  CLK,            // core clock
   input  wire logic                  RST_N,          // async reset, low
   input  wire cml_pkg::cml_req_t     REQ,            // operation request
   input  wire logic                  PAGE_CACHEABLE, // page_cacheable_bit
   input  wire logic                  PROT_VIOL,      // protection fault
   input  wire cml_pkg::cml_store_t   STORE,          // core store beat
   input  wire cml_pkg::cml_ifill_t   IFILL,          // icache line loaded
   input  wire logic                  FILL_ACK,       // fill finished
   input  wire logic                  WB_ACK,         // write-back finished
   output logic                       BUSY,           // write-back pending
   output logic                       DONE,           // operation complete
   output logic                       PTR_WE,         // pointer update
   output logic [31:0]                PTR_NEW,        // updated pointer
   output cml_pkg::cml_mem_req_t      FILL,           // line fill request
   output cml_pkg::cml_mem_req_t      WB              // line write-back req
);
   import cml_pkg::*;

   cml_regs_t st_q;
   cml_regs_t st_d;

   // [R13] line index ignores byte offset
   function automatic logic [IDX_W-1:0] line_idx(input logic [31:0] a);
      line_idx = a[OFS_W +: IDX_W];
   endfunction : line_idx

   function automatic logic [TAG_W-1:0] line_tag(input logic [31:0] a);
      line_tag = a[ADDR_W-1 -: TAG_W];
   endfunction : line_tag

   logic [IDX_W-1:0] rq_idx;
   logic [IDX_W-1:0] st_idx;
   logic [IDX_W-1:0] fl_idx;
   logic [IDX_W-1:0] if_idx;
   logic [IDX_W-1:0] op_idx;
   logic             rq_dhit;
   logic             rq_dirty;
   logic             rq_ihit;
   logic             st_hit;
   logic             taken;

   assign rq_idx   = line_idx(REQ.addr);
   assign st_idx   = line_idx(STORE.addr);
   assign fl_idx   = line_idx(st_q.fill.addr);
   assign if_idx   = line_idx(IFILL.addr);
   assign op_idx   = line_idx(st_q.addr);
   assign rq_dhit  = st_q.d_valid[rq_idx]
                     && (st_q.d_tag[rq_idx] == line_tag(REQ.addr));
   assign rq_dirty = rq_dhit && st_q.d_dirty[rq_idx];
   assign rq_ihit  = st_q.i_valid[rq_idx]
                     && (st_q.i_tag[rq_idx] == line_tag(REQ.addr));
   assign st_hit   = st_q.d_valid[st_idx]
                     && (st_q.d_tag[st_idx] == line_tag(STORE.addr));
   assign taken    = REQ.valid && (st_q.state == ST_IDLE);

   always_comb begin
      st_d        = st_q;
      st_d.done   = 1'b0;
      st_d.ptr_we = 1'b0;

      unique case (st_q.state)
         ST_IDLE: begin
            if (REQ.valid) begin
               st_d.op       = REQ.op;
               st_d.addr     = REQ.addr;
               st_d.post_inc = REQ.post_inc;
               // [R10] pointer advances by one line
               st_d.ptr_new  = REQ.addr + LINE_INC;
               st_d.ptr_we   = REQ.post_inc;
               st_d.done     = 1'b1;
               // [R9] violation completes as a no-op
               if (!PROT_VIOL) begin
                  unique case (REQ.op)
                     OP_PREFETCH: begin
                        // [R2] [R3] fill only on cacheable miss, none busy
                        if (!rq_dhit && PAGE_CACHEABLE && !st_q.fill.req)
                        begin
                           st_d.fill.req  = 1'b1;
                           st_d.fill.addr = REQ.addr & LINE_MASK;
                        end
                     end
                     OP_WRITEBACK, OP_WB_INV: begin
                        if (rq_dirty) begin
                           // [R1] [R4] [R6] whole line goes out first
                           st_d.state   = ST_WB;
                           st_d.busy    = 1'b1;
                           st_d.done    = 1'b0;
                           st_d.ptr_we  = 1'b0;
                           st_d.wb.req  = 1'b1;
                           st_d.wb.addr = REQ.addr & LINE_MASK;
                        end else if (REQ.op == OP_WB_INV && rq_dhit) begin
                           // [R6] clean hit drops straight away
                           st_d.d_valid[rq_idx] = 1'b0;
                        end
                        // [R5] [R7] clean or absent: nothing else
                     end
                     OP_I_INV: begin
                        // [R8] icache holds no dirty state
                        if (rq_ihit) begin
                           st_d.i_valid[rq_idx] = 1'b0;
                        end
                     end
                  endcase
               end
            end
         end
         ST_WB: begin
            if (WB_ACK) begin
               // [R4] [R6] written out: clean, or gone
               st_d.state           = ST_IDLE;
               st_d.busy            = 1'b0;
               st_d.wb.req          = 1'b0;
               st_d.done            = 1'b1;
               st_d.ptr_we          = st_q.post_inc;
               st_d.d_dirty[op_idx] = 1'b0;
               if (st_q.op == OP_WB_INV) begin
                  st_d.d_valid[op_idx] = 1'b0;
               end
            end
         end
      endcase

      // returning fill installs a clean line; placed after the case so
      // a same-cycle invalidate of the old line cannot drop the new one
      if (st_q.fill.req && FILL_ACK) begin
         st_d.fill.req        = 1'b0;
         st_d.d_valid[fl_idx] = 1'b1;
         st_d.d_dirty[fl_idx] = 1'b0;
         st_d.d_tag[fl_idx]   = line_tag(st_q.fill.addr);
      end
      if (IFILL.valid) begin
         st_d.i_valid[if_idx] = 1'b1;
         st_d.i_tag[if_idx]   = line_tag(IFILL.addr);
      end

      // [R12] store after clears so a same-cycle store keeps dirty
      if (STORE.valid && STORE.wb_policy && st_hit) begin
         st_d.d_dirty[st_idx] = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q <= REGS_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign BUSY    = st_q.busy;
   assign DONE    = st_q.done;
   assign PTR_WE  = st_q.ptr_we;
   assign PTR_NEW = st_q.ptr_new;
   assign FILL    = st_q.fill;
   assign WB      = st_q.wb;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_take(cml_op_t o);
      taken && !PROT_VIOL && REQ.op == o;
   endsequence

   sequence s_quiet_done;
      DONE && !WB.req && !BUSY;
   endsequence

   property p_line_aligned;
      FILL.addr[OFS_W-1:0] == '0 && WB.addr[OFS_W-1:0] == '0;
   endproperty
   a_line_aligned: assert property (p_line_aligned) // [R1] [R13]
      else $error("line address not aligned to 32 bytes");

   property p_prefetch_fill;
      s_take(OP_PREFETCH) ##0 (!rq_dhit && PAGE_CACHEABLE && !FILL.req)
      |=> FILL.req && FILL.addr == ($past(REQ.addr) & LINE_MASK) && DONE;
   endproperty
   a_prefetch_fill: assert property (p_prefetch_fill) // [R2]
      else $error("prefetch miss did not start a fill");

   property p_prefetch_nop;
      s_take(OP_PREFETCH) ##0 (rq_dhit || FILL.req)
      |=> s_quiet_done ##0 $stable(FILL.addr);
   endproperty
   a_prefetch_nop: assert property (p_prefetch_nop) // [R3]
      else $error("prefetch on hit or busy fill had an effect");

   sequence s_wb_pending;
      WB.req && BUSY && !DONE;
   endsequence

   property p_wb_dirty;
      s_take(OP_WRITEBACK) ##0 rq_dirty
      |=> s_wb_pending ##0 WB.addr == ($past(REQ.addr) & LINE_MASK);
   endproperty
   a_wb_dirty: assert property (p_wb_dirty) // [R4]
      else $error("write-back of dirty line did not start");

   property p_wb_hold;
      st_q.state == ST_WB && !WB_ACK |=> s_wb_pending;
   endproperty
   a_wb_hold: assert property (p_wb_hold) // [R4] [R6]
      else $error("write-back request dropped before acknowledge");

   property p_wb_done;
      (st_q.state == ST_WB && st_q.op == OP_WRITEBACK && WB_ACK
       && !(STORE.valid && STORE.wb_policy && st_hit && st_idx == op_idx))
      |=> DONE && !BUSY && !WB.req && !st_q.d_dirty[$past(op_idx)]
          && st_q.d_valid[$past(op_idx)];
   endproperty
   a_wb_done: assert property (p_wb_done) // [R4]
      else $error("written line not left clean and valid");

   property p_wb_clean;
      s_take(OP_WRITEBACK) ##0 !rq_dirty |=> s_quiet_done;
   endproperty
   a_wb_clean: assert property (p_wb_clean) // [R5]
      else $error("write-back of clean line was not a no-op");

   property p_wbinv_done;
      (st_q.state == ST_WB && st_q.op == OP_WB_INV && WB_ACK
       && !(st_q.fill.req && FILL_ACK && fl_idx == op_idx))
      |=> DONE && !st_q.d_valid[$past(op_idx)] && !WB.req;
   endproperty
   a_wbinv_done: assert property (p_wbinv_done) // [R6]
      else $error("write-back-invalidate left line valid");

   property p_wbinv_miss;
      s_take(OP_WB_INV) ##0 (!rq_dhit && !(st_q.fill.req && FILL_ACK))
      |=> s_quiet_done ##0 $stable(st_q.d_valid);
   endproperty
   a_wbinv_miss: assert property (p_wbinv_miss) // [R7]
      else $error("write-back-invalidate miss changed state");

   property p_iinv;
      s_take(OP_I_INV) ##0 (rq_ihit && !IFILL.valid)
      |=> s_quiet_done ##0 !st_q.i_valid[$past(rq_idx)];
   endproperty
   a_iinv: assert property (p_iinv) // [R8]
      else $error("instruction invalidate misbehaved");

   property p_prot_nop;
      taken && PROT_VIOL && !(st_q.fill.req && FILL_ACK)
      |=> s_quiet_done ##0 $stable(st_q.d_valid) ##0 $stable(FILL.addr);
   endproperty
   a_prot_nop: assert property (p_prot_nop) // [R9]
      else $error("protection violation did not act as no-op");

   property p_post_inc;
      PTR_WE |-> DONE && PTR_NEW == st_q.addr + LINE_INC;
   endproperty
   a_post_inc: assert property (p_post_inc) // [R10]
      else $error("pointer not advanced by one line");

   property p_store_dirty;
      STORE.valid && STORE.wb_policy && st_hit |=> st_q.d_dirty[$past(st_idx)];
   endproperty
   a_store_dirty: assert property (p_store_dirty) // [R12]
      else $error("store hit did not mark line dirty");
endmodule : cml_line_maint
`default_nettype wire

// *** cml_pkg.sv ***
// cml_pkg.sv: constants and types for cache line maintenance
package cml_pkg;
   localparam int unsigned ADDR_W     = 32;
   localparam int unsigned LINE_BYTES = 32;
   localparam int unsigned OFS_W      = 5;
   localparam int unsigned IDX_W      = 4;
   localparam int unsigned LINES      = 16;
   localparam int unsigned TAG_W      = ADDR_W - OFS_W - IDX_W;
   localparam logic [31:0] LINE_INC   = 32'h0000_0020;
   localparam logic [31:0] LINE_MASK  = 32'hFFFF_FFE0;

   typedef enum logic [1:0] {
      OP_PREFETCH  = 2'b00,
      OP_WRITEBACK = 2'b01,
      OP_WB_INV    = 2'b10,
      OP_I_INV     = 2'b11
   } cml_op_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_WB   = 1'b1
   } cml_fsm_t;

   typedef struct packed {
      logic              valid;
      cml_op_t           op;
      logic              post_inc;
      logic [ADDR_W-1:0] addr;
   } cml_req_t;

   typedef struct packed {
      logic              valid;
      logic              wb_policy;
      logic [ADDR_W-1:0] addr;
   } cml_store_t;

   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
   } cml_ifill_t;

   typedef struct packed {
      logic              req;
      logic [ADDR_W-1:0] addr;
   } cml_mem_req_t;

   typedef struct packed {
      cml_fsm_t                     state;
      logic                         busy;
      logic                         done;
      logic                         ptr_we;
      logic [ADDR_W-1:0]            ptr_new;
      cml_op_t                      op;
      logic                         post_inc;
      logic [ADDR_W-1:0]            addr;
      cml_mem_req_t                 fill;
      cml_mem_req_t                 wb;
      logic [LINES-1:0]             d_valid;
      logic [LINES-1:0]             d_dirty;
      logic [LINES-1:0][TAG_W-1:0]  d_tag;
      logic [LINES-1:0]             i_valid;
      logic [LINES-1:0][TAG_W-1:0]  i_tag;
   } cml_regs_t;

   localparam cml_regs_t REGS_RST = '0;
endpackage : cml_pkg

// *** cml_mem_model.sv ***
// cml_mem_model.sv: next-level memory answering fills and write-backs
`timescale 1ns/10ps
`default_nettype none
module cml_mem_model (
   input  wire logic                  clk,      // core clock
   input  wire logic                  rst_n,    // async reset, low
   input  wire cml_pkg::cml_mem_req_t fill,     // line fill request
   input  wire cml_pkg::cml_mem_req_t wb,       // write-back request
   input  wire logic [3:0]            lat,      // answer delay, cycles
   output logic                       fill_ack, // fill finished pulse
   output logic                       wb_ack,   // line taken pulse
   output int                         n_fill,   // fills answered
   output int                         n_wb,     // write-backs answered
   output logic [31:0]                wb_addr   // last line written
);
   import cml_pkg::*;
   logic [3:0] f_cnt;
   logic [3:0] w_cnt;
   // one ack per request; lat of zero answers at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fill_ack <= 1'b0;
         wb_ack   <= 1'b0;
         f_cnt    <= 4'h0;
         w_cnt    <= 4'h0;
         n_fill   <= 0;
         n_wb     <= 0;
         wb_addr  <= 32'h0;
      end else begin
         fill_ack <= 1'b0;
         wb_ack   <= 1'b0;
         f_cnt    <= (fill.req && !fill_ack) ? f_cnt + 4'h1 : 4'h0;
         w_cnt    <= (wb.req && !wb_ack) ? w_cnt + 4'h1 : 4'h0;
         if (fill.req && !fill_ack && f_cnt == lat) begin
            fill_ack <= 1'b1;
            n_fill   <= n_fill + 1;
         end
         if (wb.req && !wb_ack && w_cnt == lat) begin
            wb_ack  <= 1'b1;
            n_wb    <= n_wb + 1;
            wb_addr <= wb.addr;
         end
      end
   end
endmodule : cml_mem_model
`default_nettype wire

// *** cml_line_maint_tb.sv ***
// cml_line_maint_tb.sv: self-checking bench for line maintenance
`timescale 1ns/10ps
`default_nettype none
module cml_line_maint_tb;
   import cml_pkg::*;
   typedef struct {
      logic [1:0]  pre;   // 1 dirtying store first, 2 icache fill first
      cml_op_t     op;
      logic [31:0] addr;
      logic        cach;
      logic        prot;
      logic        pinc;
      int          fills;
      int          wbs;
   } cml_row_t;
   logic         clk, rst_n, cach, prot, fill_ack, wb_ack;
   logic         busy, done, ptr_we;
   logic [31:0]  ptr_new, wb_addr;
   logic [3:0]   lat;
   cml_req_t     req;
   cml_store_t   store;
   cml_ifill_t   ifill;
   cml_mem_req_t fill, wb;
   int           n_fill, n_wb, n_errors, total_checks, f0, w0, k;
   cml_row_t rows [13] = '{
      '{0, OP_PREFETCH,  32'h1000_0044, 1, 0, 1, 1, 0},
      '{0, OP_PREFETCH,  32'h1000_005F, 1, 0, 0, 0, 0},
      '{0, OP_PREFETCH,  32'h2000_0000, 0, 0, 0, 0, 0},
      '{0, OP_PREFETCH,  32'h3000_0000, 1, 1, 1, 0, 0},
      '{0, OP_WRITEBACK, 32'h1000_0040, 1, 0, 0, 0, 0},
      '{1, OP_WRITEBACK, 32'h1000_0041, 1, 0, 1, 0, 1},
      '{0, OP_WRITEBACK, 32'h1000_0041, 1, 0, 0, 0, 0},
      '{1, OP_WB_INV,    32'h1000_005C, 1, 0, 1, 0, 1},
      '{0, OP_PREFETCH,  32'h1000_0040, 1, 0, 0, 1, 0},
      '{0, OP_WB_INV,    32'h4000_0000, 1, 0, 0, 0, 0},
      '{2, OP_I_INV,     32'h1000_0040, 1, 0, 1, 0, 0},
      '{1, OP_WB_INV,    32'h1000_0040, 1, 1, 0, 0, 0},
      '{0, OP_WB_INV,    32'h1000_0040, 1, 0, 0, 0, 1}
   };

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   cml_line_maint dut (
      .CLK(clk), .RST_N(rst_n), .REQ(req), .PAGE_CACHEABLE(cach),
      .PROT_VIOL(prot), .STORE(store), .IFILL(ifill),
      .FILL_ACK(fill_ack), .WB_ACK(wb_ack), .BUSY(busy), .DONE(done),
      .PTR_WE(ptr_we), .PTR_NEW(ptr_new), .FILL(fill), .WB(wb));

   cml_mem_model mem (
      .clk(clk), .rst_n(rst_n), .fill(fill), .wb(wb), .lat(lat),
      .fill_ack(fill_ack), .wb_ack(wb_ack), .n_fill(n_fill),
      .n_wb(n_wb), .wb_addr(wb_addr));

   task automatic stop_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   task automatic check(input logic [32:0] got, exp, input string m);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h", $time, m, got);
      end
   endtask : check

   // store under write-back policy, or icache line load
   task automatic pre_op(input logic [1:0] kind, input logic [31:0] a);
      @(posedge clk);
      if (kind == 2'h1)
         store <= '{1'b1, 1'b1, a};
      else
         ifill <= '{1'b1, a};
      @(posedge clk);
      store.valid <= 1'b0;
      ifill.valid <= 1'b0;
   endtask : pre_op

   task automatic run_op(input cml_op_t op, input logic [31:0] a,
                         input logic c, p, i);
      @(posedge clk);
      req  <= '{1'b1, op, i, a};
      cach <= c;
      prot <= p;
      @(posedge clk);
      req.valid <= 1'b0;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (done !== 1'b1 && k < 40);
      check(k < 40, 1, "no completion");
      check(ptr_we, i, "pointer strobe");
      if (i)
         check(ptr_new, a + LINE_INC, "pointer value");
   endtask : run_op

   task automatic wait_fill;
      k = 0;
      while (fill.req !== 1'b0 && k < 40) begin
         @(negedge clk);
         k++;
      end
   endtask : wait_fill

   initial begin
      repeat (4000) @(posedge clk);
      n_errors++;
      stop_test();
   end

   initial begin
      rst_n = 1'b0;
      req   = '0;
      store = '0;
      ifill = '0;
      cach  = 1'b0;
      prot  = 1'b0;
      lat   = 4'h2;
      n_errors = 0;
      total_checks = 0;
      // checked late: a time-zero reset edge may be missed
      repeat (5) @(posedge clk);
      check({busy, done, ptr_we, fill.req, wb.req}, 0, "reset outputs");
      rst_n <= 1'b1;
      foreach (rows[r]) begin
         f0 = n_fill;
         w0 = n_wb;
         if (rows[r].pre != 2'h0)
            pre_op(rows[r].pre, rows[r].addr);
         run_op(rows[r].op, rows[r].addr, rows[r].cach, rows[r].prot,
                rows[r].pinc);
         if (rows[r].fills != 0)
            check(fill, {1'b1, rows[r].addr & LINE_MASK}, "fill");
         wait_fill();
         check(n_fill - f0, rows[r].fills, "fill count");
         check(n_wb - w0, rows[r].wbs, "write-backs");
         if (rows[r].wbs != 0)
            check(wb_addr, rows[r].addr & LINE_MASK, "wb line");
      end
      // second prefetch while the first fill is still outstanding
      lat <= 4'hA;
      f0 = n_fill;
      run_op(OP_PREFETCH, 32'h5000_0000, 1'b1, 1'b0, 1'b0);
      run_op(OP_PREFETCH, 32'h6000_0020, 1'b1, 1'b0, 1'b1);
      check(fill, {1'b1, 32'h5000_0000}, "fill line kept");
      wait_fill();
      check(n_fill - f0, 1, "fills while busy");
      // reset in mid-run empties the tags
      @(posedge clk);
      rst_n <= 1'b0;
      @(negedge clk);
      check({busy, done, ptr_we, fill.req, wb.req}, 0, "reset outputs");
      @(posedge clk);
      rst_n <= 1'b1;
      run_op(OP_PREFETCH, 32'h5000_0000, 1'b1, 1'b0, 1'b0);
      wait_fill();
      check(n_fill, 1, "refill after reset");
      stop_test();
   end
endmodule : cml_line_maint_tb
`default_nettype wire
